// ### design/cfo_config.sv
// option flags, temperature calibration and remote on/off control registers
// Functional notes
// - mandatory check set: drop writes lacking valid check
// - check bit: 0 optional, 1 required
// - bit 6 enables hybrid ratio regulation
// - hybrid mode keeps duty headroom below maximum
// - hybrid mode: output tracks input below warn limit
// - bit 5: 0 linear, 1 non-linear droop
// - bit 3 enables adaptive ramp load compensation
// - bit 2 enables dynamic bus voltage
// - bits 0, 1 and 4 reserved, no function
// - 16-bit temperature offset added to internal reading
// - remote temperature is slope times voltage plus offset
// - calibration bytes 0-1 offset, 2-3 slope
// - bit 4: pin OR versus AND combination
// - bit 2: ignore or honour the remote pin
// - bit 1: pin active high or low
// - bit 0 low: soft-stop ramp over fall time
// - bit 0 high: immediate shutdown
`timescale 1ns/1ps
module cfo_config
  import cfo_pkg::*;
#(
  parameter int DUTY_W   = 10,
  parameter int TEMP_W   = 16,
  parameter int LEVEL_W  = 16
)
(
  input  wire logic                 sys_clk,
  input  wire logic                 rstn,
  input  wire cfo_wr_t              wr,
  input  wire logic                 rd_en,
  input  wire logic [7:0]           rd_cmd,
  output logic [31:0]               rd_data,
  output logic                      rd_hit,
  output logic                      wr_rejected,
  output cfo_opts_t                 opts,
  input  wire logic [DUTY_W-1:0]    duty_demand,
  input  wire logic [DUTY_W-1:0]    duty_max,
  input  wire logic [DUTY_W-1:0]    duty_headroom,
  output logic [DUTY_W-1:0]         duty_cmd,
  input  wire logic                 vin_below_warn,
  output logic                      ratio_track,
  input  wire logic [TEMP_W-1:0]    int_temp_raw,
  output logic [TEMP_W-1:0]         int_temp,
  input  wire logic [15:0]          remote_adc,
  output logic [31:0]               remote_temp,
  input  wire logic                 primary_remote_onoff_pin,
  input  wire logic                 operation_on,
  input  wire logic                 ctrl_pin_on,
  input  wire logic [LEVEL_W-1:0]   fall_step,
  output logic [LEVEL_W-1:0]        out_level,
  output logic                      out_enable
);
  logic [7:0]     special_option_flags;          // option flags register
  logic [15:0]    internal_temp_offset;          // internal temperature offset
  logic [31:0]    remote_temp_calibration;       // remote calibration block
  logic [7:0]     remote_onoff_pin_config;       // remote pin configuration
  logic [7:0]     next_special_option_flags;     // next option flags
  logic [15:0]    next_internal_temp_offset;     // next temperature offset
  logic [31:0]    next_remote_temp_calibration;  // next calibration
  logic [7:0]     next_remote_onoff_pin_config;  // next pin configuration
  logic           wr_ok;                         // write passes check policy
  logic           wr_rejected_q;                 // registered reject flag
  logic           next_wr_rejected;              // next reject flag
  logic [31:0]    rd_data_q;                     // registered read data
  logic           rd_hit_q;                      // registered read hit
  logic [31:0]    next_rd_data;                  // next read data
  logic           next_rd_hit;                   // next read hit
  logic           pin_active;                    // pin after polarity
  logic           run_request;                   // combined on request
  cfo_out_state_t out_state;                     // output stage state
  cfo_out_state_t next_out_state;                // next output state
  logic [LEVEL_W-1:0] level;                     // output level
  logic [LEVEL_W-1:0] next_level;                // next output level
  logic [DUTY_W-1:0]  duty_q;                    // registered duty
  logic [DUTY_W-1:0]  next_duty;                 // next duty
  logic           track_q;                       // registered tracking flag
  logic           next_track;                    // next tracking flag
  logic [TEMP_W-1:0]  int_temp_q;                // registered internal temp
  logic [TEMP_W-1:0]  next_int_temp;             // next internal temp
  logic [31:0]    rtemp_q;                       // registered remote temp
  logic [31:0]    next_rtemp;                    // next remote temp
  logic           ramp_tick;                     // ramp step enable
  logic [LEVEL_W-1:0] full_level;                // full-scale output level

  assign full_level = {LEVEL_W{1'b1}};

  // write acceptance policy
  always_comb
  begin
    wr_ok = 1'b1;
    if (special_option_flags[CFO_SO_PEC_REQ] == 1'b1)
      wr_ok = wr.pec_present & wr.pec_ok;
    else if (wr.pec_present)
      wr_ok = wr.pec_ok;
  end

  // register writes, reserved bits masked off
  always_comb
  begin
    next_special_option_flags    = special_option_flags;
    next_internal_temp_offset    = internal_temp_offset;
    next_remote_temp_calibration = remote_temp_calibration;
    next_remote_onoff_pin_config = remote_onoff_pin_config;
    next_wr_rejected             = 1'b0;
    if (wr.valid && !wr_ok)
    begin
      next_wr_rejected = 1'b1;
    end
    else if (wr.valid)
    begin
      if (wr.cmd == CFO_CMD_SPECIAL)
        next_special_option_flags = wr.data[7:0] & CFO_SO_MASK;
      else if (wr.cmd == CFO_CMD_TEMP_OFS)
        next_internal_temp_offset = wr.data[15:0];
      else if (wr.cmd == CFO_CMD_REM_CAL)
        next_remote_temp_calibration = wr.data;
      else if (wr.cmd == CFO_CMD_REM_CTRL)
        next_remote_onoff_pin_config = wr.data[7:0] & CFO_RC_MASK;
    end
  end

  // register storage
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      special_option_flags    <= CFO_RST_SPECIAL;
      internal_temp_offset    <= CFO_RST_TEMP_OFS;
      remote_temp_calibration <= CFO_RST_REM_CAL;
      remote_onoff_pin_config <= CFO_RST_REM_CTRL;
      wr_rejected_q           <= 1'b0;
    end
    else
    begin
      special_option_flags    <= next_special_option_flags;
      internal_temp_offset    <= next_internal_temp_offset;
      remote_temp_calibration <= next_remote_temp_calibration;
      remote_onoff_pin_config <= next_remote_onoff_pin_config;
      wr_rejected_q           <= next_wr_rejected;
    end
  end

  // read decode, unknown command answers zero with no hit
  always_comb
  begin
    next_rd_data = 32'h0000_0000;
    next_rd_hit  = 1'b0;
    if (!rd_en)
    begin
      next_rd_data = rd_data_q;
    end
    else if (rd_cmd == CFO_CMD_SPECIAL)
    begin
      next_rd_data = {24'h000000, special_option_flags};
      next_rd_hit  = 1'b1;
    end
    else if (rd_cmd == CFO_CMD_TEMP_OFS)
    begin
      next_rd_data = {16'h0000, internal_temp_offset};
      next_rd_hit  = 1'b1;
    end
    else if (rd_cmd == CFO_CMD_REM_CAL)
    begin
      next_rd_data = remote_temp_calibration;
      next_rd_hit  = 1'b1;
    end
    else if (rd_cmd == CFO_CMD_REM_CTRL)
    begin
      next_rd_data = {24'h000000, remote_onoff_pin_config};
      next_rd_hit  = 1'b1;
    end
  end

  // register read answer
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_data_q <= 32'h0000_0000;
      rd_hit_q  <= 1'b0;
    end
    else
    begin
      rd_data_q <= next_rd_data;
      rd_hit_q  <= next_rd_hit;
    end
  end

  // decoded option flags
  always_comb
  begin
    opts.pec_required            = special_option_flags[CFO_SO_PEC_REQ];
    opts.hybrid_ratio_regulation = special_option_flags[CFO_SO_HRR];
    opts.droop_slope_select      = special_option_flags[CFO_SO_DROOP];
    opts.adaptive_ramp_load_comp = special_option_flags[CFO_SO_ART];
    opts.dynamic_bus_voltage     = special_option_flags[CFO_SO_DBV];
  end

  // duty limiting, ratio tracking and temperature conversion
  always_comb
  begin
    next_duty     = duty_demand;
    next_track    = 1'b0;
    if (special_option_flags[CFO_SO_HRR])
    begin
      if (duty_headroom >= duty_max)
        next_duty = '0;  // no room left below the limit
      else if (duty_demand >= duty_max - duty_headroom)
        next_duty = duty_max - duty_headroom - DUTY_W'(duty_headroom == '0);
      next_track = vin_below_warn;
    end
    else if (duty_demand > duty_max)
    begin
      next_duty = duty_max;
    end
    next_int_temp = int_temp_raw + TEMP_W'(internal_temp_offset);
    // slope in bytes 2-3, offset in bytes 0-1
    next_rtemp = 32'(remote_temp_calibration[31:16] * remote_adc)
               + {16'h0000, remote_temp_calibration[15:0]};
  end

  // register derived outputs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      duty_q     <= '0;
      track_q    <= 1'b0;
      int_temp_q <= '0;
      rtemp_q    <= 32'h0000_0000;
    end
    else
    begin
      duty_q     <= next_duty;
      track_q    <= next_track;
      int_temp_q <= next_int_temp;
      rtemp_q    <= next_rtemp;
    end
  end

  // combine the remote pin with the operation command and control pin
  always_comb
  begin
    pin_active = primary_remote_onoff_pin ^ remote_onoff_pin_config[CFO_RC_POL];
    if (!remote_onoff_pin_config[CFO_RC_EN])
      run_request = operation_on & ctrl_pin_on;
    else if (remote_onoff_pin_config[CFO_RC_AND])
      run_request = pin_active & operation_on & ctrl_pin_on;
    else
      run_request = pin_active | operation_on | ctrl_pin_on;
  end

  // output stage: on, off, or soft-stop ramp
  always_comb
  begin
    next_out_state = out_state;
    next_level     = level;
    case (out_state)
      CFO_OUT_OFF:
      begin
        next_level = '0;
        if (run_request)
          next_out_state = CFO_OUT_ON;
      end
      CFO_OUT_ON:
      begin
        next_level = full_level;
        if (!run_request && remote_onoff_pin_config[CFO_RC_QUICK])
        begin
          next_level     = '0;
          next_out_state = CFO_OUT_OFF;
        end
        else if (!run_request)
          next_out_state = CFO_OUT_RAMP;
      end
      CFO_OUT_RAMP:
      begin
        if (run_request)
          next_out_state = CFO_OUT_ON;
        else if (remote_onoff_pin_config[CFO_RC_QUICK])
        begin
          next_level     = '0;
          next_out_state = CFO_OUT_OFF;
        end
        else if (ramp_tick && level <= fall_step)
        begin
          next_level     = '0;
          next_out_state = CFO_OUT_OFF;
        end
        else if (ramp_tick)
          next_level = level - fall_step;
      end
      default:
      begin
        next_out_state = CFO_OUT_OFF;
        next_level     = '0;
      end
    endcase
  end

  // register output stage
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_state <= CFO_OUT_OFF;
      level     <= '0;
    end
    else
    begin
      out_state <= next_out_state;
      level     <= next_level;
    end
  end

  // paces the ramp steps
  cfo_ramp_div #(
    .DIV (CFO_RAMP_DIV)
  ) u_div (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .run     (out_state == CFO_OUT_RAMP),
    .tick    (ramp_tick)
  );

  assign rd_data     = rd_data_q;
  assign rd_hit      = rd_hit_q;
  assign wr_rejected = wr_rejected_q;
  assign duty_cmd    = duty_q;
  assign ratio_track = track_q;
  assign int_temp    = int_temp_q;
  assign remote_temp = rtemp_q;
  assign out_level   = level;
  assign out_enable  = (out_state != CFO_OUT_OFF);
endmodule

// ### design/cfo_pkg.sv
// shared constants and types for the converter option and on/off configuration block
package cfo_pkg;
  // command codes of the four configuration registers
  localparam logic [7:0] CFO_CMD_SPECIAL   = 8'hE0;
  localparam logic [7:0] CFO_CMD_TEMP_OFS  = 8'hE1;
  localparam logic [7:0] CFO_CMD_REM_CAL   = 8'hE2;
  localparam logic [7:0] CFO_CMD_REM_CTRL  = 8'hE3;
  // byte counts of each register
  localparam int CFO_LEN_SPECIAL  = 1;
  localparam int CFO_LEN_TEMP_OFS = 2;
  localparam int CFO_LEN_REM_CAL  = 4;
  localparam int CFO_LEN_REM_CTRL = 1;
  // special option bit positions
  localparam int CFO_SO_PEC_REQ  = 7;
  localparam int CFO_SO_HRR      = 6;
  localparam int CFO_SO_DROOP    = 5;
  localparam int CFO_SO_ART      = 3;
  localparam int CFO_SO_DBV      = 2;
  localparam logic [7:0] CFO_SO_MASK = 8'hEC;
  // remote on/off bit positions
  localparam int CFO_RC_AND      = 4;
  localparam int CFO_RC_EN       = 2;
  localparam int CFO_RC_POL      = 1;
  localparam int CFO_RC_QUICK    = 0;
  localparam logic [7:0] CFO_RC_MASK = 8'h17;
  // reset values
  localparam logic [7:0]  CFO_RST_SPECIAL  = 8'h00;
  localparam logic [15:0] CFO_RST_TEMP_OFS = 16'h0000;
  localparam logic [31:0] CFO_RST_REM_CAL  = 32'h0000_0000;
  localparam logic [7:0]  CFO_RST_REM_CTRL = 8'h00;
  // ramp-down tick divider (one enable pulse per step)
  localparam int CFO_RAMP_DIV = 100;

  // decoded option flags that steer the regulation logic
  typedef struct packed {
    logic pec_required;
    logic hybrid_ratio_regulation;
    logic droop_slope_select;
    logic adaptive_ramp_load_comp;
    logic dynamic_bus_voltage;
  } cfo_opts_t;

  // write request from the command interface
  typedef struct packed {
    logic        valid;
    logic [7:0]  cmd;
    logic [31:0] data;
    logic        pec_present;
    logic        pec_ok;
  } cfo_wr_t;

  // output-stage control states
  typedef enum logic [2:0] {
    CFO_OUT_OFF  = 3'b001,
    CFO_OUT_ON   = 3'b010,
    CFO_OUT_RAMP = 3'b100
  } cfo_out_state_t;
endpackage

// ### design/cfo_ramp_div.sv
// enable pulse divider that paces the soft-stop ramp
`timescale 1ns/1ps
module cfo_ramp_div
  import cfo_pkg::*;
#(
  parameter int DIV = CFO_RAMP_DIV
)
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic run,
  output logic      tick
);
  logic [15:0] cnt;       // divider count
  logic [15:0] next_cnt;  // next divider count

  // count up while running, wrap at the divide value
  always_comb
  begin
    next_cnt = cnt;
    tick     = 1'b0;
    if (!run)
    begin
      next_cnt = 16'h0000;
    end
    else if (cnt == 16'(DIV - 1))
    begin
      next_cnt = 16'h0000;
      tick     = 1'b1;
    end
    else
    begin
      next_cnt = cnt + 16'h0001;
    end
  end

  // register the count
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      cnt <= 16'h0000;
    else
      cnt <= next_cnt;
  end
endmodule

// ### tb/cfo_monitor.sv
// assertion checker bound to the configuration block
`timescale 1ns/1ps
module cfo_monitor
  import cfo_pkg::*;
#(
  parameter int DUTY_W  = 10,
  parameter int LEVEL_W = 16
)
(
  input wire logic               sys_clk,
  input wire logic               rstn,
  input wire cfo_wr_t            wr,
  input wire logic               rd_en,
  input wire logic [7:0]         rd_cmd,
  input wire logic [31:0]        rd_data,
  input wire logic               wr_rejected,
  input wire cfo_opts_t          opts,
  input wire logic [DUTY_W-1:0]  duty_max,
  input wire logic [DUTY_W-1:0]  duty_cmd,
  input wire logic               vin_below_warn,
  input wire logic               ratio_track,
  input wire logic [LEVEL_W-1:0] fall_step,
  input wire logic [LEVEL_W-1:0] out_level,
  input wire logic               out_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // write that the check policy must drop
  sequence s_bad_wr;
    wr.valid && opts.pec_required && !(wr.pec_present && wr.pec_ok);
  endsequence
  // option read with no write around it, then its answer cycle
  sequence s_opt_rd;
    rd_en && rd_cmd == CFO_CMD_SPECIAL && !wr.valid && !$past(wr.valid) ##1 1'b1;
  endsequence
  a_reject_bad: assert property (s_bad_wr |=> wr_rejected)
    else $error("write without valid check byte was kept");
  a_no_pec_ok: assert property (wr.valid && !opts.pec_required && !wr.pec_present
    |=> !wr_rejected)
    else $error("optional check byte write was dropped");
  a_reject_cause: assert property (wr_rejected |-> $past(wr.valid))
    else $error("reject pulse without a write");
  a_opt_readback: assert property (s_opt_rd |-> rd_data == {24'h0, opts.pec_required,
    opts.hybrid_ratio_regulation, opts.droop_slope_select, 1'b0,
    opts.adaptive_ramp_load_comp, opts.dynamic_bus_voltage, 2'b00})
    else $error("option flags disagree with option register");
  a_ctrl_reserved: assert property (rd_en && rd_cmd == CFO_CMD_REM_CTRL
    |=> (rd_data & 32'hFFFF_FFE8) == 32'h0)
    else $error("reserved on/off bits read nonzero");
  a_ratio_track: assert property (ratio_track == $past(opts.hybrid_ratio_regulation
    && vin_below_warn))
    else $error("ratio tracking flag wrong");
  a_duty_room: assert property ($past(opts.hybrid_ratio_regulation) && $past(duty_max) != 0
    |-> duty_cmd < $past(duty_max))
    else $error("duty reached maximum in hybrid mode");
  a_ramp_step: assert property (out_enable && $past(out_enable) && out_level != '1
    && out_level != $past(out_level) |-> out_level == $past(out_level) - $past(fall_step))
    else $error("ramp step size wrong");
  a_off_zero: assert property (!out_enable |-> out_level == '0)
    else $error("output level nonzero while off");
endmodule

bind cfo_config cfo_monitor #(.DUTY_W(DUTY_W), .LEVEL_W(LEVEL_W)) cfo_monitor_i (
  .sys_clk(sys_clk), .rstn(rstn), .wr(wr), .rd_en(rd_en), .rd_cmd(rd_cmd),
  .rd_data(rd_data), .wr_rejected(wr_rejected), .opts(opts), .duty_max(duty_max),
  .duty_cmd(duty_cmd), .vin_below_warn(vin_below_warn), .ratio_track(ratio_track),
  .fall_step(fall_step), .out_level(out_level), .out_enable(out_enable));

// ### tb/cfo_host_model.sv
// host model issuing command writes and reads
`timescale 1ns/1ps
module cfo_host_model
  import cfo_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit,
  input  wire logic        wr_rejected,
  output cfo_wr_t          wr,
  output logic             rd_en,
  output logic [7:0]       rd_cmd
);
  // idle bus at time zero
  initial
  begin
    wr = '0;
    rd_en = 1'b0;
    rd_cmd = 8'h00;
  end
  // one write held over one rising edge; reject pulse caught in either next cycle
  task automatic wr_reg(input logic [7:0] cmd, input logic [31:0] data, input logic pec,
                        input logic good, output logic rej);
    @(negedge sys_clk);
    wr.valid = 1'b1;
    wr.cmd = cmd;
    wr.data = data;
    wr.pec_present = pec;
    wr.pec_ok = good;
    @(posedge sys_clk);
    @(negedge sys_clk);
    wr.valid = 1'b0;
    wr.data = ~data;
    rej = wr_rejected;
    @(negedge sys_clk);
    rej = rej | wr_rejected;
  endtask
  // one read; answer taken in the cycle after the sampling edge
  task automatic rd_reg(input logic [7:0] cmd, output logic [31:0] data, output logic hit);
    @(negedge sys_clk);
    rd_en = 1'b1;
    rd_cmd = cmd;
    @(posedge sys_clk);
    @(negedge sys_clk);
    rd_en = 1'b0;
    rd_cmd = ~cmd;
    data = rd_data;
    hit = rd_hit;
  endtask
endmodule

// ### tb/converter_option_onoff_config_tb_top.sv
// self-checking bench for the configuration block
`timescale 1ns/1ps
module converter_option_onoff_config_tb_top;
  import cfo_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn, rd_en, rd_hit, wr_rejected, vin_below_warn, ratio_track;
  logic primary_remote_onoff_pin, operation_on, ctrl_pin_on, out_enable;
  logic [7:0] rd_cmd;
  logic [31:0] rd_data, remote_temp;
  logic [9:0] duty_demand, duty_max, duty_headroom, duty_cmd;
  logic [15:0] int_temp_raw, int_temp, remote_adc, fall_step, out_level;
  cfo_wr_t wr;
  cfo_opts_t opts;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  // on/off cases: config, pin, operation, control pin, expected enable
  logic [11:0] oc [5] = '{{8'h05, 4'b1001}, {8'h15, 4'b1100}, {8'h07, 4'b0001},
                          {8'h01, 4'b1000}, {8'h11, 4'b1111}};

  cfo_config cfo_config_i (.sys_clk(sys_clk), .rstn(rstn), .wr(wr), .rd_en(rd_en),
    .rd_cmd(rd_cmd), .rd_data(rd_data), .rd_hit(rd_hit), .wr_rejected(wr_rejected),
    .opts(opts), .duty_demand(duty_demand), .duty_max(duty_max),
    .duty_headroom(duty_headroom), .duty_cmd(duty_cmd), .vin_below_warn(vin_below_warn),
    .ratio_track(ratio_track), .int_temp_raw(int_temp_raw), .int_temp(int_temp),
    .remote_adc(remote_adc), .remote_temp(remote_temp),
    .primary_remote_onoff_pin(primary_remote_onoff_pin), .operation_on(operation_on),
    .ctrl_pin_on(ctrl_pin_on), .fall_step(fall_step), .out_level(out_level),
    .out_enable(out_enable));
  cfo_host_model cfo_host_model_i (.sys_clk(sys_clk), .rd_data(rd_data), .rd_hit(rd_hit),
    .wr_rejected(wr_rejected), .wr(wr), .rd_en(rd_en), .rd_cmd(rd_cmd));

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // hang guard
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      close_out();
    end
  end
  // compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // read and compare data and hit
  task automatic rd_chk(input logic [7:0] cmd, input logic [31:0] exp, input logic hit);
    logic [31:0] d;
    logic h;
    cfo_host_model_i.rd_reg(cmd, d, h);
    check("rd_data", d, exp);
    check("rd_hit", {31'h0, h}, {31'h0, hit});
  endtask
  // write, compare the reject pulse, then read back
  task automatic wr_rd(input logic [7:0] cmd, input logic [31:0] data, input logic pec,
                       input logic good, input logic rej, input logic [31:0] exp);
    logic r;
    cfo_host_model_i.wr_reg(cmd, data, pec, good, r);
    check("wr_rejected", {31'h0, r}, {31'h0, rej});
    rd_chk(cmd, exp, 1'b1);
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial
  begin
    int n;
    rstn = 1'b0;
    {primary_remote_onoff_pin, operation_on, ctrl_pin_on} = 3'b000;
    duty_demand = 10'h3FF;
    duty_max = 10'h200;
    duty_headroom = 10'h010;
    vin_below_warn = 1'b1;
    int_temp_raw = 16'hFFF0;
    remote_adc = 16'h0100;
    fall_step = 16'h4000;
    repeat (16) @(posedge sys_clk);
    @(negedge sys_clk);
    rstn = 1'b1;
    // reset values and an unmapped command
    rd_chk(CFO_CMD_SPECIAL, 32'h0, 1'b1);
    rd_chk(CFO_CMD_REM_CTRL, 32'h0, 1'b1);
    rd_chk(8'hE4, 32'h0, 1'b0);
    wr_rd(CFO_CMD_SPECIAL, 32'h0000_00FF, 1'b0, 1'b0, 1'b0, 32'h0000_00EC);
    check("opts", {27'h0, opts}, 32'h1F);
    wr_rd(CFO_CMD_SPECIAL, 32'h0000_006C, 1'b0, 1'b0, 1'b1, 32'h0000_00EC);
    wr_rd(CFO_CMD_SPECIAL, 32'h0000_006C, 1'b1, 1'b1, 1'b0, 32'h0000_006C);
    check("opts", {27'h0, opts}, 32'h0F);
    check("duty_below_max", {31'h0, duty_cmd < duty_max}, 32'h1);
    check("ratio_track", {31'h0, ratio_track}, 32'h1);
    vin_below_warn = 1'b0;
    repeat (2) @(negedge sys_clk);
    check("ratio_track", {31'h0, ratio_track}, 32'h0);
    vin_below_warn = 1'b1;
    wr_rd(CFO_CMD_SPECIAL, 32'h0, 1'b1, 1'b0, 1'b1, 32'h0000_006C);
    wr_rd(CFO_CMD_SPECIAL, 32'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    check("opts", {27'h0, opts}, 32'h0);
    wr_rd(CFO_CMD_SPECIAL, 32'h0000_0024, 1'b0, 1'b0, 1'b0, 32'h0000_0024);
    check("opts", {27'h0, opts}, 32'h05);
    check("ratio_track", {31'h0, ratio_track}, 32'h0);
    check("duty_clamp", {22'h0, duty_cmd}, 32'h200);
    duty_demand = 10'h100;
    repeat (2) @(negedge sys_clk);
    check("duty_pass", {22'h0, duty_cmd}, 32'h100);
    // temperature offset and remote calibration
    wr_rd(CFO_CMD_TEMP_OFS, 32'hABCD_0123, 1'b0, 1'b0, 1'b0, 32'h0000_0123);
    check("int_temp", {16'h0, int_temp}, 32'h0000_0113);
    wr_rd(CFO_CMD_REM_CAL, 32'h0003_0010, 1'b0, 1'b0, 1'b0, 32'h0003_0010);
    check("remote_temp", remote_temp, 32'h0000_0310);
    wr_rd(CFO_CMD_REM_CTRL, 32'h0000_00FF, 1'b0, 1'b0, 1'b0, 32'h0000_0017);
    // pin combination, enable and polarity, all with quick off
    foreach (oc[i])
    begin
      wr_rd(CFO_CMD_REM_CTRL, {24'h0, oc[i][11:4]}, 1'b0, 1'b0, 1'b0, {24'h0, oc[i][11:4]});
      {primary_remote_onoff_pin, operation_on, ctrl_pin_on} = oc[i][3:1];
      repeat (3) @(negedge sys_clk);
      check("out_enable", {31'h0, out_enable}, {31'h0, oc[i][0]});
    end
    // quick off: gone one edge after the request drops
    ctrl_pin_on = 1'b0;
    @(negedge sys_clk);
    check("quick_off", {15'h0, out_enable, out_level}, 32'h0);
    // soft stop: ramp down in fall_step decrements
    wr_rd(CFO_CMD_REM_CTRL, 32'h0000_0004, 1'b0, 1'b0, 1'b0, 32'h0000_0004);
    {primary_remote_onoff_pin, operation_on} = 2'b10;
    repeat (3) @(negedge sys_clk);
    check("full_scale", {15'h0, out_enable, out_level}, 32'h0001_FFFF);
    primary_remote_onoff_pin = 1'b0;
    n = 0;
    while (out_enable === 1'b1 && n < 1000)
    begin
      @(negedge sys_clk);
      n++;
    end
    // four steps of 0x4000 empty full scale, one divider period each, plus the entry edge
    check("ramp_len", n, 4 * CFO_RAMP_DIV + 1);
    close_out();
  end
endmodule
